// file: common/shr_pkg.sv
// Shared constants, types and check-field arithmetic for the sensor readout link
package shr_pkg;
  // Device byte map
  localparam logic [7:0] ADDR_PART = 8'h00;
  localparam logic [7:0] ADDR_SERIAL = 8'h04;
  localparam logic [7:0] ADDR_SYSTEM_CONTROL = 8'h10;
  localparam logic [7:0] ADDR_POWER_STATE_STATUS = 8'h11;
  localparam logic [7:0] ADDR_RUN = 8'h21;
  localparam logic [7:0] ADDR_START = 8'h22;
  localparam logic [7:0] ADDR_STOP = 8'h23;
  localparam logic [7:0] ADDR_MSTAT = 8'h24;
  localparam logic [7:0] ADDR_TEMP = 8'h30;
  localparam logic [7:0] ADDR_HUM = 8'h33;
  localparam logic [7:0] ADDR_RSVD = 8'h36;
  localparam logic [7:0] PART_BYTES = 8'h02;
  localparam logic [7:0] SERIAL_BYTES = 8'h08;
  localparam logic [7:0] READOUT_BYTES = 8'h03;
  // Identity value is arbitrary
  localparam logic [15:0] PART_NUMBER = 16'h5a3c;
  // Control fields and reset values
  localparam int LOW_POWER_BIT = 0;
  localparam int SOFT_RESET_BIT = 7;
  localparam logic LOW_POWER_RST = 1'b1;
  // Readout word layout and scaling
  localparam int DATA_W = 16;
  localparam int VALID_BIT = 16;
  localparam int CHECK_LSB = 17;
  localparam int CHECK_W = 7;
  localparam int PAYLOAD_W = 17;
  localparam int TEMP_FRAC_BITS = 6;
  localparam int HUM_FRAC_BITS = 9;
  localparam logic [7:0] CHECK_POLYNOMIAL = 8'h89;
  localparam logic [6:0] CHECK_INITIAL_VECTOR = 7'h7f;
  // Timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int BOOT_TIME_NS = 100;
  localparam int BOOT_CYCLES = (BOOT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Host APB map
  localparam logic [7:0] HC_CMD = 8'h00;
  localparam logic [7:0] HC_WDATA = 8'h04;
  localparam logic [7:0] HC_STATUS = 8'h08;
  localparam logic [7:0] HC_RDLO = 8'h0c;
  localparam logic [7:0] HC_RDHI = 8'h10;
  localparam int CMD_WRITE_BIT = 8;
  localparam int CMD_COUNT_LSB = 9;
  localparam int ST_BUSY_BIT = 0;
  localparam int ST_NACK_BIT = 1;
  localparam int ST_TCHK_BIT = 2;
  localparam int ST_HCHK_BIT = 3;

  typedef enum logic [1:0] {OP_ADDR, OP_WRITE, OP_READ} shr_op_t;

  function automatic logic [6:0] check7(input logic [16:0] val);
    logic [23:0] v;
    logic [23:0] pol;
    v = {val, CHECK_INITIAL_VECTOR};
    pol = {CHECK_POLYNOMIAL, 16'h0000};
    for (int i = 0; i < PAYLOAD_W; i++) begin
      if (v[23 - i]) begin
        v = v ^ (pol >> i);
      end
    end
    return v[6:0];
  endfunction : check7

  function automatic logic [23:0] make_word(input logic [15:0] data, input logic valid);
    return {check7({valid, data}), valid, data};
  endfunction : make_word
endpackage : shr_pkg

// file: common/shr_link_if.sv
// Byte-level register link between the host controller and the sensor device
`timescale 1ns/1ps
interface shr_link_if;
  logic req;
  shr_pkg::shr_op_t op;
  logic [7:0] wdata;
  logic done;
  logic nack;
  logic [7:0] rdata;
  modport dev (input req, input op, input wdata, output done, output nack, output rdata);
  modport host (output req, output op, output wdata, input done, input nack, input rdata);
endinterface : shr_link_if

// file: rtl/shr_device.sv
// Sensor device end: register map, power state, measurement steps and readout words
`timescale 1ns/1ps
// Function
// - Check field is CRC-7, polynomial 0x89
// - CRC starts from initial vector 0x7F
// - Shift payload, XOR polynomial per set bit
// - Word: data 15:0, valid 16, check 23:17
// - Readout bytes little endian, lowest address first
// - Temperature field is kelvin times 64
// - Humidity field is percent times 512
// - Identity registers read valid only when active
// - Host reads identity by disabling auto-standby
// - Host may read identity during a measurement
// - Multi-byte registers span consecutive byte addresses
// - Part number at 0x00, serial at 0x04
// - Run mode register at 0x21, read/write
// - Measuring status register at 0x24, read-only
// - Readouts at 0x30 and 0x33; 0x36 up reserved
// - Host starts both by writing 03 to 0x22
// - Host reads both readouts in 6-byte burst
// - Reserved addresses read as zero
// - Writes to reserved or read-only addresses nacked
module shr_device (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Register link
  shr_link_if.dev lnk,
  // Sensor side: index 0 temperature, 1 humidity
  input wire logic [63:0] unique_serial,
  input wire logic [1:0] sns_done,
  input wire logic [1:0][15:0] sns_data,
  output logic [1:0] sns_measure,
  output logic active_state_flag
);
  typedef enum logic [1:0] {PWR_STANDBY, PWR_BOOTING, PWR_ACTIVE} shr_pwr_t;

  typedef struct packed {
    shr_pwr_t pwr;
    logic [7:0] boot_cnt;
    logic low_power;
    logic [1:0] run_mode;
    logic [1:0] start_pend;
    logic [1:0] stop_pend;
    logic [1:0] again;
    logic [1:0] measuring;
    logic [1:0][23:0] word;
    logic [1:0][23:0] snap;
    logic [7:0] cra;
    logic done;
    logic nack;
    logic [7:0] rdata;
  } shr_dev_st_t;

  localparam shr_dev_st_t ST_RST = '{pwr: PWR_BOOTING, low_power: shr_pkg::LOW_POWER_RST, default: '0};

  shr_dev_st_t r_reg;
  shr_dev_st_t r_next;

  function automatic logic in_span(input logic [7:0] a, input logic [7:0] base, input logic [7:0] len);
    return (a >= base) && (a < base + len);
  endfunction : in_span

  function automatic logic [7:0] pick(input logic [63:0] v, input logic [7:0] off);
    return v[off[2:0] * 8 +: 8];
  endfunction : pick

  logic active;
  logic [7:0] rd_byte;
  logic [1:0] step_go;

  assign active = (r_reg.pwr == PWR_ACTIVE);

  // Read mux for the byte at the current register address
  always_comb begin
    logic [7:0] a;
    a = r_reg.cra;
    // Reserved, write-only and unused bytes fall through to zero
    rd_byte = 8'h00;
    if (in_span(a, shr_pkg::ADDR_PART, shr_pkg::PART_BYTES)) begin
      rd_byte = active ? pick({48'h0000_0000_0000, shr_pkg::PART_NUMBER}, a - shr_pkg::ADDR_PART) : 8'h00;
    end else if (in_span(a, shr_pkg::ADDR_SERIAL, shr_pkg::SERIAL_BYTES)) begin
      rd_byte = active ? pick(unique_serial, a - shr_pkg::ADDR_SERIAL) : 8'h00;
    end else if (a == shr_pkg::ADDR_SYSTEM_CONTROL) begin
      rd_byte = {7'h00, r_reg.low_power};
    end else if (a == shr_pkg::ADDR_POWER_STATE_STATUS) begin
      rd_byte = {7'h00, active};
    end else if (a == shr_pkg::ADDR_RUN) begin
      rd_byte = {6'h00, r_reg.run_mode};
    end else if (a == shr_pkg::ADDR_START) begin
      rd_byte = {6'h00, r_reg.start_pend};
    end else if (a == shr_pkg::ADDR_MSTAT) begin
      rd_byte = {6'h00, r_reg.measuring};
    end else if (a == shr_pkg::ADDR_TEMP) begin
      rd_byte = r_reg.word[0][7:0];
    end else if (in_span(a, shr_pkg::ADDR_TEMP, shr_pkg::READOUT_BYTES)) begin
      rd_byte = pick({40'h00_0000_0000, r_reg.snap[0]}, a - shr_pkg::ADDR_TEMP);
    end else if (a == shr_pkg::ADDR_HUM) begin
      rd_byte = r_reg.word[1][7:0];
    end else if (in_span(a, shr_pkg::ADDR_HUM, shr_pkg::READOUT_BYTES)) begin
      rd_byte = pick({40'h00_0000_0000, r_reg.snap[1]}, a - shr_pkg::ADDR_HUM);
    end
  end

  always_comb begin
    r_next = r_reg;
    r_next.done = 1'b0;
    // A continuous repeat launches like a start but keeps its valid flag
    step_go = r_reg.start_pend | r_reg.again;
    // Power state and step sequencing
    unique case (r_reg.pwr)
      PWR_STANDBY: begin
        if (!r_reg.low_power || (r_reg.start_pend != 2'b00)) begin
          r_next.pwr = PWR_BOOTING;
          r_next.boot_cnt = 8'h00;
        end
      end
      PWR_BOOTING: begin
        r_next.boot_cnt = r_reg.boot_cnt + 8'h01;
        // Identity bytes stay hidden until the full boot count has run
        if (r_reg.boot_cnt == 8'(shr_pkg::BOOT_CYCLES - 1)) begin
          r_next.pwr = PWR_ACTIVE;
        end
      end
      PWR_ACTIVE: begin
        if (r_reg.measuring == 2'b00) begin
          if (step_go != 2'b00) begin
            r_next.measuring = step_go;
            r_next.start_pend = 2'b00;
            r_next.again = 2'b00;
            for (int s = 0; s < 2; s++) begin
              if (r_reg.start_pend[s] && !r_reg.again[s]) begin
                r_next.word[s] = shr_pkg::make_word(r_reg.word[s][15:0], 1'b0);
              end
            end
          end else if (r_reg.low_power) begin
            r_next.pwr = PWR_STANDBY;
          end
        end
      end
      default: r_next.pwr = PWR_BOOTING;
    endcase
    // Measurement completion: data 1/64 K for temperature, 1/512 %RH for humidity
    for (int s = 0; s < 2; s++) begin
      if (r_reg.measuring[s] && sns_done[s]) begin
        r_next.measuring[s] = 1'b0;
        r_next.word[s] = shr_pkg::make_word(sns_data[s], 1'b1);
        r_next.again[s] = r_reg.run_mode[s] && !r_reg.stop_pend[s];
        r_next.stop_pend[s] = 1'b0;
      end
    end
    // Link access with auto-incrementing register address
    if (lnk.req && !r_reg.done) begin
      r_next.done = 1'b1;
      r_next.nack = 1'b0;
      unique case (lnk.op)
        shr_pkg::OP_ADDR: r_next.cra = lnk.wdata;
        shr_pkg::OP_WRITE: begin
          r_next.cra = r_reg.cra + 8'h01;
          if (r_reg.cra == shr_pkg::ADDR_SYSTEM_CONTROL) begin
            if (lnk.wdata[shr_pkg::SOFT_RESET_BIT]) begin
              // Soft reset restores every field, yet the write itself is still answered
              r_next = ST_RST;
              r_next.done = 1'b1;
            end else begin
              r_next.low_power = lnk.wdata[shr_pkg::LOW_POWER_BIT];
            end
          end else if (r_reg.cra == shr_pkg::ADDR_RUN) begin
            r_next.run_mode = lnk.wdata[1:0];
          end else if (r_reg.cra == shr_pkg::ADDR_START) begin
            // Built on the next value, so a start written in the launch cycle is kept
            r_next.start_pend = r_next.start_pend | lnk.wdata[1:0];
          end else if (r_reg.cra == shr_pkg::ADDR_STOP) begin
            // A stop only matters to a continuous sensor; single shot drops it
            r_next.stop_pend = r_next.stop_pend | (lnk.wdata[1:0] & r_reg.run_mode);
          end else begin
            // Read-only and reserved bytes refuse the write and store nothing
            r_next.nack = 1'b1;
          end
        end
        shr_pkg::OP_READ: begin
          r_next.cra = r_reg.cra + 8'h01;
          r_next.rdata = rd_byte;
          // Lowest byte read freezes the whole word for the following bytes
          if (r_reg.cra == shr_pkg::ADDR_TEMP) begin
            r_next.snap[0] = r_reg.word[0];
          end
          if (r_reg.cra == shr_pkg::ADDR_HUM) begin
            r_next.snap[1] = r_reg.word[1];
          end
        end
        default: r_next.nack = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r_reg <= ST_RST;
    end else begin
      r_reg <= r_next;
    end
  end

  assign lnk.done = r_reg.done;
  assign lnk.nack = r_reg.nack;
  assign lnk.rdata = r_reg.rdata;
  assign sns_measure = r_reg.measuring;
  assign active_state_flag = active;
endmodule : shr_device

// file: rtl/shr_host.sv
// Host controller end: APB command registers driving byte bursts over the link
`timescale 1ns/1ps
module shr_host (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Register link
  shr_link_if.host lnk
);
  typedef enum logic [1:0] {H_IDLE, H_ADDR, H_XFER} shr_hst_t;

  typedef struct packed {
    shr_hst_t st;
    logic req;
    shr_pkg::shr_op_t op;
    logic [7:0] wdata;
    logic [7:0] addr;
    logic write;
    logic [2:0] cnt;
    logic [2:0] idx;
    logic [31:0] wbuf;
    logic [47:0] rbuf;
    logic nack;
    logic [31:0] prdata;
  } shr_host_st_t;

  shr_host_st_t r_reg;
  shr_host_st_t r_next;

  logic mapped;
  logic [23:0] t_word;
  logic [23:0] h_word;
  logic [31:0] status;

  assign mapped = (paddr == shr_pkg::HC_CMD) || (paddr == shr_pkg::HC_WDATA) || (paddr == shr_pkg::HC_STATUS) ||
                  (paddr == shr_pkg::HC_RDLO) || (paddr == shr_pkg::HC_RDHI);
  assign t_word = r_reg.rbuf[23:0];
  assign h_word = r_reg.rbuf[47:24];

  always_comb begin
    status = 32'h0000_0000;
    status[shr_pkg::ST_BUSY_BIT] = (r_reg.st != H_IDLE);
    status[shr_pkg::ST_NACK_BIT] = r_reg.nack;
    status[shr_pkg::ST_TCHK_BIT] = (shr_pkg::check7(t_word[16:0]) == t_word[23:17]);
    status[shr_pkg::ST_HCHK_BIT] = (shr_pkg::check7(h_word[16:0]) == h_word[23:17]);
  end

  always_comb begin
    r_next = r_reg;
    // Read data registered in the setup cycle, shown in the access cycle
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        shr_pkg::HC_CMD: r_next.prdata = {20'h0_0000, r_reg.cnt, r_reg.write, r_reg.addr};
        shr_pkg::HC_WDATA: r_next.prdata = r_reg.wbuf;
        shr_pkg::HC_STATUS: r_next.prdata = status;
        shr_pkg::HC_RDLO: r_next.prdata = r_reg.rbuf[31:0];
        shr_pkg::HC_RDHI: r_next.prdata = {16'h0000, r_reg.rbuf[47:32]};
        default: r_next.prdata = 32'h0000_0000;
      endcase
    end
    if (psel && penable && pwrite) begin
      if (paddr == shr_pkg::HC_WDATA) begin
        r_next.wbuf = pwdata;
      end else if ((paddr == shr_pkg::HC_CMD) && (r_reg.st == H_IDLE)) begin
        r_next.addr = pwdata[7:0];
        r_next.write = pwdata[shr_pkg::CMD_WRITE_BIT];
        r_next.cnt = pwdata[shr_pkg::CMD_COUNT_LSB +: 3];
        r_next.nack = 1'b0;
        r_next.st = H_ADDR;
      end
    end
    // Link sequencing: address byte, then a burst of data bytes
    unique case (r_reg.st)
      H_IDLE: r_next.req = 1'b0;
      H_ADDR: begin
        if (!r_reg.req) begin
          r_next.req = 1'b1;
          r_next.op = shr_pkg::OP_ADDR;
          r_next.wdata = r_reg.addr;
        end else if (lnk.done) begin
          r_next.req = 1'b0;
          r_next.idx = 3'h0;
          r_next.st = (r_reg.cnt == 3'h0) ? H_IDLE : H_XFER;
        end
      end
      H_XFER: begin
        if (!r_reg.req) begin
          r_next.req = 1'b1;
          r_next.op = r_reg.write ? shr_pkg::OP_WRITE : shr_pkg::OP_READ;
          r_next.wdata = r_reg.wbuf[r_reg.idx[1:0] * 8 +: 8];
        end else if (lnk.done) begin
          r_next.req = 1'b0;
          r_next.nack = r_reg.nack | lnk.nack;
          if (!r_reg.write) begin
            r_next.rbuf[r_reg.idx * 8 +: 8] = lnk.rdata;
          end
          r_next.idx = r_reg.idx + 3'h1;
          if (r_reg.idx == r_reg.cnt - 3'h1) begin
            r_next.st = H_IDLE;
          end
        end
      end
      default: r_next.st = H_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (srst) begin
      r_reg <= '{st: H_IDLE, op: shr_pkg::OP_ADDR, default: '0};
    end else begin
      r_reg <= r_next;
    end
  end

  assign prdata = r_reg.prdata;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !mapped;
  assign lnk.req = r_reg.req;
  assign lnk.op = r_reg.op;
  assign lnk.wdata = r_reg.wdata;
endmodule : shr_host

// file: dv/shr_link_assertions.sv
// Link protocol and register map checks between host and device ends
`timescale 1ns/1ps
module shr_link_assertions (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Link
  input wire logic req,
  input shr_pkg::shr_op_t op,
  input wire logic [7:0] wdata,
  input wire logic done,
  input wire logic nack,
  input wire logic [7:0] rdata
);
  logic [7:0] cra_reg;
  logic take;
  assign take = req && !done;
  // Shadow of the current register address
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      cra_reg <= 8'h00;
    end else if (take) begin
      cra_reg <= (op == shr_pkg::OP_ADDR) ? wdata : cra_reg + 8'h01;
    end
  end
  function automatic logic wr_ok(input logic [7:0] a);
    return a == 8'h10 || a == 8'h21 || a == 8'h22 || a == 8'h23;
  endfunction : wr_ok
  function automatic logic rd_zero(input logic [7:0] a);
    return a == 8'h23 || (a >= 8'h0c && a <= 8'h0f) || (a >= 8'h12 && a <= 8'h20) ||
      (a >= 8'h25 && a <= 8'h2f) || a >= 8'h36;
  endfunction : rd_zero
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_answer; take |=> done; endproperty
  a_answer: assert property (p_answer) else $error("link request not answered next cycle");
  property p_pulse; done |=> !done; endproperty
  a_pulse: assert property (p_pulse) else $error("answer longer than one cycle");
  property p_cause; done |-> $past(req) && !$past(done); endproperty
  a_cause: assert property (p_cause) else $error("answer without request");
  property p_hold; take |=> req && $stable(op) && $stable(wdata); endproperty
  a_hold: assert property (p_hold) else $error("request changed before answer");
  property p_gap; req && done |=> !req; endproperty
  a_gap: assert property (p_gap) else $error("request not dropped after answer");
  property p_nack_bad; take && op == shr_pkg::OP_WRITE && !wr_ok(cra_reg) |=> done && nack; endproperty
  a_nack_bad: assert property (p_nack_bad) else $error("refused write acknowledged");
  property p_nack_ok; take && op == shr_pkg::OP_WRITE && wr_ok(cra_reg) |=> !nack; endproperty
  a_nack_ok: assert property (p_nack_ok) else $error("legal write refused");
  property p_rsvd_zero; take && op == shr_pkg::OP_READ && rd_zero(cra_reg) |=> rdata == 8'h00; endproperty
  a_rsvd_zero: assert property (p_rsvd_zero) else $error("reserved byte read nonzero");
  property p_stand; !done |-> $stable(nack) && $stable(rdata); endproperty
  a_stand: assert property (p_stand) else $error("answer fields changed between answers");
  c_nack: cover property (take && op == shr_pkg::OP_WRITE && !wr_ok(cra_reg));
  c_read: cover property (take && op == shr_pkg::OP_READ);
  c_addr: cover property (take && op == shr_pkg::OP_ADDR);
endmodule : shr_link_assertions

// file: dv/sensor_register_map_crc7_readout_tb.sv
// Testbench: APB host commands over the link to the sensor device end
`timescale 1ns/1ps
module sensor_register_map_crc7_readout_tb;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [63:0] unique_serial = 64'h0000_0000_0000_0000;
  logic [1:0] sns_done = 2'b00;
  logic [1:0][15:0] sns_data = '0;
  logic [1:0] sns_measure;
  logic active_state_flag;
  logic [31:0] got = 32'h0000_0000;
  logic got_v = 1'b0;
  logic err_seen = 1'b0;
  logic [31:0] exp_q[$];
  logic [31:0] msk_q[$];
  int bad_count = 0;
  int checks_done = 0;
  shr_link_if lnk ();
  shr_host shr_host_inst (.clk_sys(clk_sys), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .lnk(lnk));
  shr_device shr_device_inst (.clk_sys(clk_sys), .srst(srst), .lnk(lnk), .unique_serial(unique_serial),
    .sns_done(sns_done), .sns_data(sns_data), .sns_measure(sns_measure), .active_state_flag(active_state_flag));
  shr_link_assertions shr_link_assertions_inst (.clk_sys(clk_sys), .srst(srst), .req(lnk.req), .op(lnk.op),
    .wdata(lnk.wdata), .done(lnk.done), .nack(lnk.nack), .rdata(lnk.rdata));
  initial begin
    forever #2.5 clk_sys = ~clk_sys;
  end
  task automatic stop_test;
    if (bad_count == 0 && checks_done > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : stop_test
  task automatic cmp32(input logic [31:0] e, input logic [31:0] m, input logic [31:0] g);
    checks_done++;
    if ((g & m) !== (e & m)) begin
      bad_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e & m, g & m);
    end
  endtask : cmp32
  task automatic cmp_flags(input logic [2:0] e);
    int k;
    k = 0;
    while ({active_state_flag, sns_measure} !== e && k < 500) begin
      @(negedge clk_sys);
      k++;
    end
    checks_done++;
    if ({active_state_flag, sns_measure} !== e) begin
      bad_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, e, {active_state_flag, sns_measure});
    end
  endtask : cmp_flags
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    r = prdata;
    err_seen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // One link burst: optional data byte, then poll until the host is idle
  task automatic lcmd(input logic [7:0] a, input logic w, input logic [2:0] n, input logic [7:0] d);
    logic [31:0] r;
    int k;
    if (w) apb(1'b1, shr_pkg::HC_WDATA, {24'h00_0000, d}, r);
    apb(1'b1, shr_pkg::HC_CMD, {20'h0_0000, n, w, a}, r);
    k = 0;
    r = 32'h0000_0001;
    while (r[shr_pkg::ST_BUSY_BIT] !== 1'b0 && k < 200) begin
      apb(1'b0, shr_pkg::HC_STATUS, 32'h0000_0000, r);
      k++;
    end
    if (r[shr_pkg::ST_BUSY_BIT] !== 1'b0) begin
      bad_count++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, 1'b0, r[shr_pkg::ST_BUSY_BIT]);
    end
  endtask : lcmd
  task automatic chk(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
    logic [31:0] r;
    exp_q.push_back(e);
    msk_q.push_back(m);
    apb(1'b0, a, 32'h0000_0000, r);
    got <= r;
    got_v <= 1'b1;
    @(posedge clk_sys);
    got_v <= 1'b0;
  endtask : chk
  // Error response of an unmapped host register
  task automatic chk_err(input logic [7:0] a);
    logic [31:0] r;
    exp_q.push_back(32'h0000_0001);
    msk_q.push_back(32'h0000_0001);
    apb(1'b0, a, 32'h0000_0000, r);
    got <= {31'h0000_0000, err_seen};
    got_v <= 1'b1;
    @(posedge clk_sys);
    got_v <= 1'b0;
  endtask : chk_err
  always @(posedge clk_sys) begin
    if (got_v === 1'b1) cmp32(exp_q.pop_front(), msk_q.pop_front(), got);
  end
  function automatic logic [23:0] word(input logic [15:0] dv, input logic vb);
    logic [23:0] v;
    v = {vb, dv, 7'h7f};
    for (int i = 0; i < 17; i++) begin
      if (v[23 - i]) v = v ^ (24'h89_0000 >> i);
    end
    return {v[6:0], vb, dv};
  endfunction : word
  initial begin
    #100us;
    bad_count++;
    stop_test();
  end
  initial begin
    logic [15:0] td, hd, pt, ph;
    logic [23:0] tw, hw;
    void'($urandom(32'h7f9f));
    unique_serial <= {$urandom(), $urandom()};
    pt = 16'h0000;
    ph = 16'h0000;
    repeat (4) @(posedge clk_sys);
    srst <= 1'b0;
    lcmd(shr_pkg::ADDR_SYSTEM_CONTROL, 1'b1, 3'd1, 8'h00);
    cmp_flags(3'b100);
    lcmd(shr_pkg::ADDR_POWER_STATE_STATUS, 1'b0, 3'd1, 8'h00);
    chk(shr_pkg::HC_RDLO, 32'h0000_0001, 32'h0000_00ff);
    lcmd(shr_pkg::ADDR_PART, 1'b0, 3'd2, 8'h00);
    chk(shr_pkg::HC_RDLO, {16'h0000, shr_pkg::PART_NUMBER}, 32'h0000_ffff);
    lcmd(shr_pkg::ADDR_SERIAL, 1'b0, 3'd4, 8'h00);
    chk(shr_pkg::HC_RDLO, unique_serial[31:0], 32'hffff_ffff);
    lcmd(8'h08, 1'b0, 3'd4, 8'h00);
    chk(shr_pkg::HC_RDLO, unique_serial[63:32], 32'hffff_ffff);
    lcmd(shr_pkg::ADDR_RUN, 1'b1, 3'd1, 8'h02);
    lcmd(shr_pkg::ADDR_RUN, 1'b0, 3'd1, 8'h00);
    chk(shr_pkg::HC_RDLO, 32'h0000_0002, 32'h0000_00ff);
    chk(8'h14, 32'h0000_0000, 32'hffff_ffff);
    chk_err(8'h14);
    lcmd(shr_pkg::ADDR_RUN, 1'b1, 3'd1, 8'h00);
    lcmd(shr_pkg::ADDR_TEMP, 1'b1, 3'd1, 8'h55);
    chk(shr_pkg::HC_STATUS, 32'h0000_0002, 32'h0000_0002);
    lcmd(shr_pkg::ADDR_RSVD, 1'b0, 3'd4, 8'h00);
    chk(shr_pkg::HC_RDLO, 32'h0000_0000, 32'hffff_ffff);
    lcmd(shr_pkg::ADDR_SYSTEM_CONTROL, 1'b1, 3'd1, 8'h01);
    cmp_flags(3'b000);
    lcmd(shr_pkg::ADDR_PART, 1'b0, 3'd2, 8'h00);
    chk(shr_pkg::HC_RDLO, 32'h0000_0000, 32'h0000_ffff);
    for (int i = 0; i < 2; i++) begin
      td = (i == 0) ? 16'h49fd : 16'($urandom());
      hd = (i == 0) ? 16'h2e6c : 16'($urandom());
      lcmd(shr_pkg::ADDR_START, 1'b1, 3'd1, 8'h03);
      cmp_flags(3'b111);
      lcmd(shr_pkg::ADDR_MSTAT, 1'b0, 3'd1, 8'h00);
      chk(shr_pkg::HC_RDLO, 32'h0000_0003, 32'h0000_00ff);
      lcmd(shr_pkg::ADDR_PART, 1'b0, 3'd2, 8'h00);
      chk(shr_pkg::HC_RDLO, {16'h0000, shr_pkg::PART_NUMBER}, 32'h0000_ffff);
      tw = word(pt, 1'b0);
      hw = word(ph, 1'b0);
      if (i > 0) begin
        lcmd(shr_pkg::ADDR_TEMP, 1'b0, 3'd6, 8'h00);
        chk(shr_pkg::HC_RDLO, {hw[7:0], tw}, 32'hffff_ffff);
      end
      @(posedge clk_sys);
      sns_data <= {hd, td};
      sns_done <= 2'b11;
      @(posedge clk_sys);
      sns_done <= 2'b00;
      cmp_flags(3'b000);
      tw = (i == 0) ? 24'h0b_49fd : word(td, 1'b1);
      hw = (i == 0) ? 24'hf5_2e6c : word(hd, 1'b1);
      lcmd(shr_pkg::ADDR_TEMP, 1'b0, 3'd6, 8'h00);
      chk(shr_pkg::HC_RDLO, {hw[7:0], tw}, 32'hffff_ffff);
      chk(shr_pkg::HC_RDHI, {16'h0000, hw[23:8]}, 32'h0000_ffff);
      chk(shr_pkg::HC_STATUS, 32'h0000_000c, 32'h0000_000c);
      pt = td;
      ph = hd;
    end
    // Continuous temperature: one repeat keeps valid, then a stop ends the run
    lcmd(shr_pkg::ADDR_RUN, 1'b1, 3'd1, 8'h01);
    lcmd(shr_pkg::ADDR_START, 1'b1, 3'd1, 8'h01);
    cmp_flags(3'b101);
    for (int j = 0; j < 2; j++) begin
      td = 16'($urandom());
      if (j > 0) lcmd(shr_pkg::ADDR_STOP, 1'b1, 3'd1, 8'h01);
      @(posedge clk_sys);
      sns_data <= {hd, td};
      sns_done <= 2'b01;
      @(posedge clk_sys);
      sns_done <= 2'b00;
      tw = word(td, 1'b1);
      lcmd(shr_pkg::ADDR_TEMP, 1'b0, 3'd3, 8'h00);
      chk(shr_pkg::HC_RDLO, {8'h00, tw}, 32'h00ff_ffff);
      lcmd(shr_pkg::ADDR_MSTAT, 1'b0, 3'd1, 8'h00);
      chk(shr_pkg::HC_RDLO, (j == 0) ? 32'h0000_0001 : 32'h0000_0000, 32'h0000_00ff);
    end
    // Soft reset returns the run mode to single shot
    lcmd(shr_pkg::ADDR_SYSTEM_CONTROL, 1'b1, 3'd1, 8'h80);
    lcmd(shr_pkg::ADDR_RUN, 1'b0, 3'd1, 8'h00);
    chk(shr_pkg::HC_RDLO, 32'h0000_0000, 32'h0000_00ff);
    repeat (3) @(posedge clk_sys);
    stop_test();
  end
endmodule : sensor_register_map_crc7_readout_tb
